/* File: core/scp_clkgen.v */
`default_nettype none
// ****************************************
// internal serial clock generation
// ****************************************
module scp_clkgen (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        presc8_i,
   input  wire [11:0] div_i,
   output reg         tick_o,
   output wire        phase_o
);
   reg  [2:0]  pre_r;
   reg  [11:0] cnt_r;
   reg         half_r;
   assign phase_o = half_r;
   wire        pre_tick = !presc8_i || (pre_r == 3'h7);

   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_r  <= 3'h0;
         cnt_r  <= 12'h000;
         half_r <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         pre_r  <= presc8_i ? pre_r + 3'h1 : 3'h0;
         if (pre_tick) begin
            if (cnt_r >= div_i) begin
               cnt_r  <= 12'h000;
               half_r <= ~half_r;
               tick_o <= half_r;
            end else begin
               cnt_r <= cnt_r + 12'h001;
            end
         end
      end
   end
endmodule // scp_clkgen
`default_nettype wire

/* File: core/scp_serial_port.v */
// What this block does
// - reset clears whole clock control register
// - bit 15 picks transmit clock source
// - bit 14 picks receive clock source
// - clock pin output only if both clear
// - synchronous mode shares one clock source
// - prescale 1 or 8, then halve
// - divider ratio is field plus one
// - synchronous clock out fixed divide two
// - async pin clock divided sixteen unless bit12
// - timeout sets timer interrupt when enabled
// - sync clock at bit rate, free-running
// - async output clock runs continuously
// - polarity bit picks the external clock edge for both
// - full word loads receive byte, flags
// - receive byte readable on three lanes
// - transmit byte written from three lanes
// - address location sets address bit
// - any transmit write clears empty flag
// - auto load, first bit two-three bits later
// - async frame start, data, bit9 if fmt[2], stop
// - transmit interrupt only while empty
// - status updates two cycles after writes
// - empty flag set when nothing pending
// - reading receive data clears full flag
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "scp_regs.vh"
module scp_serial_port (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire        rxd_i,
   output reg         txd_o,
   input  wire        sclk_i,
   output reg         sclk_o,
   output reg         sclk_oe_o,
   output reg         timer_irq_o,
   output reg         tx_irq_o
);
// ****************************************
// registers and pin synchronisers
// ****************************************
   reg  [23:0] serial_clock_control_r;
   reg  [23:0] serial_control_reg_r;
   reg  [7:0]  tx_data_reg_r;
   reg         tx_addr_bit_r;
   reg         tx_holding_empty_r;
   reg  [7:0]  rx_data_reg_r;
   reg         rx_holding_full_r;
   reg         framing_flag_r;
   reg         parity_flag_r;
   reg         overrun_flag_r;
   reg         r8_flag_r;
   reg         timer_pend_r;
   reg  [1:0]  rx_sync_r;
   reg  [1:0]  ck_sync_r;
   reg         ck_prev_r;
   reg  [1:0]  txe_pipe_r;
   wire        int_tick;
   wire        clk_phase;

   wire [2:0]  fmt   = serial_control_reg_r[`SCP_CR_FMT_MSB:0];
   wire        sync_mode = (fmt == `SCP_FMT_SYNC);
   wire        msb1st = serial_control_reg_r[`SCP_CR_SHDIR];
   wire        pol    = serial_control_reg_r[`SCP_CR_POL];
   wire        tx_ext = serial_clock_control_r[`SCP_CC_TXSEL];
   wire        rx_ext = serial_clock_control_r[`SCP_CC_RXSEL];
   wire        clock_out_divider_sel    = serial_clock_control_r[`SCP_CC_COD];
   wire        has_b9 = fmt[2];

   scp_clkgen u_clkgen (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .presc8_i (serial_clock_control_r[`SCP_CC_PRESC]),
      .div_i    (serial_clock_control_r[`SCP_CC_DIV_MSB:0]),
      .tick_o   (int_tick),
      .phase_o  (clk_phase)
   );

   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_sync_r <= 2'h3;
         ck_sync_r <= 2'h0;
         ck_prev_r <= 1'b0;
      end else begin
         rx_sync_r <= {rx_sync_r[0], rxd_i};
         ck_sync_r <= {ck_sync_r[0], sclk_i};
         ck_prev_r <= ck_sync_r[1];
      end
   end
   // one pulse per external clock edge, polarity picks the edge
   wire ext_tick = pol ? (ck_prev_r & ~ck_sync_r[1])
                       : (~ck_prev_r & ck_sync_r[1]);
   wire tx_tick = tx_ext ? ext_tick : int_tick;
   wire rx_src  = sync_mode ? tx_ext : rx_ext;
   wire rx_tick = rx_src ? ext_tick : int_tick;

// ****************************************
// clock pin output
// ****************************************
   reg [3:0] out_div_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         out_div_r <= 4'h0;
         sclk_o    <= 1'b0;
         sclk_oe_o <= 1'b0;
      end else begin
         sclk_oe_o <= ~tx_ext & ~rx_ext;
         if (int_tick)
            out_div_r <= out_div_r + 4'h1;
         if (!sync_mode && clock_out_divider_sel)
            sclk_o <= clk_phase;
         else if (int_tick && sync_mode)
            sclk_o <= ~sclk_o;
         else if (int_tick && out_div_r[2:0] == 3'h7)
            sclk_o <= ~sclk_o;
      end
   end

// ****************************************
// transmitter
// ****************************************
   reg  [3:0]  tx_sub_r;
   reg  [3:0]  tx_bit_r;
   reg  [10:0] tx_sh_r;
   reg         tx_busy_r;
   reg  [1:0]  tx_lead_r;
   wire        tx_bit_tick = tx_tick &&
                  (sync_mode ? tx_sub_r[0] : tx_sub_r == 4'hF);
   wire [7:0]  tx_ord = msb1st ?
      {tx_data_reg_r[0], tx_data_reg_r[1], tx_data_reg_r[2],
       tx_data_reg_r[3], tx_data_reg_r[4], tx_data_reg_r[5],
       tx_data_reg_r[6], tx_data_reg_r[7]} : tx_data_reg_r;
   wire        tx_b9 = (fmt == `SCP_FMT_MDROP) ? tx_addr_bit_r :
                       (fmt == `SCP_FMT_ODD) ? ~^tx_data_reg_r :
                       ^tx_data_reg_r;
   wire [3:0]  tx_len = sync_mode ? 4'h8 : (has_b9 ? 4'hB : 4'hA);

   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_sub_r  <= 4'h0;
         tx_bit_r  <= 4'h0;
         tx_sh_r   <= 11'h7FF;
         tx_busy_r <= 1'b0;
         tx_lead_r <= 2'h0;
         txd_o     <= 1'b1;
      end else begin
         if (tx_tick)
            tx_sub_r <= tx_sub_r + 4'h1;
         if (tx_bit_tick) begin
            if (!tx_busy_r && !tx_holding_empty_r) begin
               if (tx_lead_r == 2'h1) begin
                  tx_busy_r <= 1'b1;
                  tx_bit_r  <= 4'h0;
                  tx_lead_r <= 2'h0;
                  if (sync_mode)
                     tx_sh_r <= {3'h7, tx_ord};
                  else if (has_b9)
                     tx_sh_r <= {1'b1, tx_b9, tx_ord, 1'b0};
                  else
                     tx_sh_r <= {2'h3, tx_ord, 1'b0};
               end else begin
                  tx_lead_r <= tx_lead_r + 2'h1;
               end
            end else if (tx_busy_r) begin
               txd_o    <= tx_sh_r[0];
               tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
               tx_bit_r <= tx_bit_r + 4'h1;
               if (tx_bit_r == tx_len - 4'h1)
                  tx_busy_r <= 1'b0;
            end
         end
      end
   end
   wire tx_load = tx_bit_tick && !tx_busy_r && !tx_holding_empty_r
                  && tx_lead_r == 2'h1;

// ****************************************
// receiver
// ****************************************
   reg  [3:0]  rx_sub_r;
   reg  [3:0]  rx_bit_r;
   reg  [9:0]  rx_sh_r;
   reg         rx_busy_r;
   wire        rx_line = rx_sync_r[1];
   wire [3:0]  rx_len = sync_mode ? 4'h8 : (has_b9 ? 4'hB : 4'hA);
   wire        rx_samp = rx_tick &&
                  (sync_mode ? rx_sub_r[0] : rx_sub_r == 4'h7);
   wire        rx_done = rx_samp && rx_busy_r &&
                         rx_bit_r == rx_len - 4'h1;
   wire [9:0]  rx_word = {rx_line, rx_sh_r[9:1]};
   wire [7:0]  rx_raw = sync_mode ? rx_word[9:2] :
                        has_b9 ? rx_sh_r[8:1] : rx_word[8:1];
   wire        rx_b9 = rx_sh_r[9];
   wire [7:0]  rx_dat = msb1st ?
      {rx_raw[0], rx_raw[1], rx_raw[2], rx_raw[3],
       rx_raw[4], rx_raw[5], rx_raw[6], rx_raw[7]} : rx_raw;
   wire        rx_frm = !sync_mode && !rx_line;
   wire        rx_par = (fmt == `SCP_FMT_EVEN && (^rx_raw ^ rx_b9)) ||
                        (fmt == `SCP_FMT_ODD && !(^rx_raw ^ rx_b9));

   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_sub_r  <= 4'h0;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 10'h000;
         rx_busy_r <= 1'b0;
      end else begin
         if (!rx_busy_r && !sync_mode && rx_line)
            rx_sub_r <= 4'h0;
         else if (rx_tick)
            rx_sub_r <= rx_sub_r + 4'h1;
         if (!rx_busy_r && (sync_mode || !rx_line)) begin
            rx_busy_r <= 1'b1;
            rx_bit_r  <= 4'h0;
         end else if (rx_samp && rx_busy_r) begin
            rx_sh_r  <= {rx_line, rx_sh_r[9:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_done || (rx_bit_r == 4'h0 && !sync_mode && rx_line))
               rx_busy_r <= 1'b0;
         end
      end
   end

// ****************************************
// apb slave and flags
// ****************************************
   wire acc  = psel_i & penable_i & ~pready_o;
   wire wr   = acc & pwrite_i;
   wire rd   = acc & ~pwrite_i;
   wire wtx  = wr && (paddr_i == `SCP_OFS_TX_LOW ||
                      paddr_i == `SCP_OFS_TX_MID ||
                      paddr_i == `SCP_OFS_TX_HIGH ||
                      paddr_i == `SCP_OFS_TX_ADDR);
   wire rrx  = rd && (paddr_i == `SCP_OFS_RX_LOW ||
                      paddr_i == `SCP_OFS_RX_MID ||
                      paddr_i == `SCP_OFS_RX_HIGH);
   wire known = paddr_i == `SCP_OFS_CTRL || paddr_i == `SCP_OFS_STAT ||
                paddr_i == `SCP_OFS_CLKCTL ||
                paddr_i == `SCP_OFS_TX_LOW || paddr_i == `SCP_OFS_TX_MID ||
                paddr_i == `SCP_OFS_TX_HIGH || paddr_i == `SCP_OFS_TX_ADDR ||
                paddr_i == `SCP_OFS_RX_LOW || paddr_i == `SCP_OFS_RX_MID ||
                paddr_i == `SCP_OFS_RX_HIGH;
   reg  stat_rd_r;
   wire [23:0] status = {15'h0000, timer_pend_r, r8_flag_r,
                         framing_flag_r, parity_flag_r, overrun_flag_r,
                         1'b0, rx_holding_full_r, txe_pipe_r[1],
                         txe_pipe_r[1] & ~tx_busy_r};

   always @(posedge clk_i) begin
      if (rst_i) begin
         serial_clock_control_r <= `SCP_CC_RST;
         serial_control_reg_r   <= `SCP_CR_RST;
         tx_data_reg_r      <= 8'h00;
         tx_addr_bit_r      <= 1'b0;
         tx_holding_empty_r <= 1'b1;
         txe_pipe_r         <= 2'h3;
         rx_data_reg_r      <= 8'h00;
         rx_holding_full_r  <= 1'b0;
         framing_flag_r     <= 1'b0;
         parity_flag_r      <= 1'b0;
         overrun_flag_r     <= 1'b0;
         r8_flag_r          <= 1'b0;
         timer_pend_r       <= 1'b0;
         stat_rd_r          <= 1'b0;
         prdata_o    <= 32'h00000000;
         pready_o    <= 1'b0;
         pslverr_o   <= 1'b0;
         timer_irq_o <= 1'b0;
         tx_irq_o    <= 1'b0;
      end else begin
         pready_o  <= acc;
         pslverr_o <= acc & ~known;
         txe_pipe_r <= {txe_pipe_r[0], tx_holding_empty_r};
         if (wr && paddr_i == `SCP_OFS_CLKCTL)
            serial_clock_control_r <= {8'h00, pwdata_i[15:0]};
         if (wr && paddr_i == `SCP_OFS_CTRL)
            serial_control_reg_r <= {18'h00000, pwdata_i[5:0]};
         if (wtx) begin
            tx_holding_empty_r <= 1'b0;
            tx_addr_bit_r <= (paddr_i == `SCP_OFS_TX_ADDR);
            case (paddr_i)
               `SCP_OFS_TX_MID:  tx_data_reg_r <= pwdata_i[15:8];
               `SCP_OFS_TX_HIGH: tx_data_reg_r <= pwdata_i[23:16];
               default:          tx_data_reg_r <= pwdata_i[7:0];
            endcase
         end else if (tx_load)
            tx_holding_empty_r <= 1'b1;
         if (rd && paddr_i == `SCP_OFS_STAT)
            stat_rd_r <= 1'b1;
         else if (rrx)
            stat_rd_r <= 1'b0;
         // received word wins over a clearing read in the same cycle
         if (rx_done && !framing_flag_r) begin
            if (rx_holding_full_r && !rrx) begin
               overrun_flag_r <= 1'b1;
               framing_flag_r <= 1'b0;
               parity_flag_r  <= 1'b0;
            end else begin
               rx_data_reg_r     <= rx_dat;
               rx_holding_full_r <= 1'b1;
               framing_flag_r    <= rx_frm;
               parity_flag_r     <= rx_par;
               r8_flag_r <= (fmt == `SCP_FMT_MDROP) & rx_b9;
            end
         end else if (rrx) begin
            rx_holding_full_r <= 1'b0;
            if (stat_rd_r) begin
               framing_flag_r <= 1'b0;
               parity_flag_r  <= 1'b0;
               overrun_flag_r <= 1'b0;
            end
         end
         // a timeout in the clearing cycle keeps the flag set
         if (int_tick && serial_control_reg_r[`SCP_CR_TIMER_IRQ_ENABLE])
            timer_pend_r <= 1'b1;
         else if (rd && paddr_i == `SCP_OFS_STAT)
            timer_pend_r <= 1'b0;
         timer_irq_o <= timer_pend_r;
         tx_irq_o    <= txe_pipe_r[1];
         if (rd) begin
            case (paddr_i)
               `SCP_OFS_CTRL:    prdata_o <= {8'h00, serial_control_reg_r};
               `SCP_OFS_STAT:    prdata_o <= {8'h00, status};
               `SCP_OFS_CLKCTL:  prdata_o <= {8'h00, serial_clock_control_r};
               `SCP_OFS_RX_LOW:  prdata_o <= {24'h000000, rx_data_reg_r};
               `SCP_OFS_RX_MID:  prdata_o <= {16'h0000, rx_data_reg_r, 8'h00};
               `SCP_OFS_RX_HIGH: prdata_o <= {8'h00, rx_data_reg_r, 16'h0000};
               default:          prdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // scp_serial_port
`default_nettype wire

/* File: shared/scp_regs.vh */
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// register byte offsets
`define SCP_OFS_CTRL      12'h000
`define SCP_OFS_STAT      12'h004
`define SCP_OFS_CLKCTL    12'h008
`define SCP_OFS_RX_LOW    12'h00C
`define SCP_OFS_RX_MID    12'h010
`define SCP_OFS_RX_HIGH   12'h014
`define SCP_OFS_TX_LOW    12'h018
`define SCP_OFS_TX_MID    12'h01C
`define SCP_OFS_TX_HIGH   12'h020
`define SCP_OFS_TX_ADDR   12'h024
// clock control fields
`define SCP_CC_TXSEL      15
`define SCP_CC_RXSEL      14
`define SCP_CC_PRESC      13
`define SCP_CC_COD        12
`define SCP_CC_DIV_MSB    11
`define SCP_CC_RST        24'h000000
// control fields
`define SCP_CR_FMT_MSB    2
`define SCP_CR_SHDIR      3
`define SCP_CR_POL        4
`define SCP_CR_TIMER_IRQ_ENABLE       5
`define SCP_CR_RST        24'h000000
// status fields
`define SCP_ST_IDLE_TX    0
`define SCP_ST_TXE        1
`define SCP_ST_RXF        2
`define SCP_ST_OVR        4
`define SCP_ST_PAR        5
`define SCP_ST_FRM        6
`define SCP_ST_R8         7
`define SCP_ST_TMR        8
// word formats
`define SCP_FMT_SYNC      3'h0
`define SCP_FMT_A10       3'h2
`define SCP_FMT_EVEN      3'h4
`define SCP_FMT_ODD       3'h5
`define SCP_FMT_MDROP     3'h6
// timing
`define SCP_PRESC_DIV     4'h8
`define SCP_ASYNC_OVS     5'h10
`define SCP_STAT_DELAY    2
`endif

/* File: testbench/scp_asserts.sv */
`default_nettype none
// ****
// port checks
// ****
module scp_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        sclk_oe_o,
   input wire logic        tx_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic        rd_ok = pready_o && !pwrite_i;
   wire logic [31:0] lane = 32'h000000FF << ((paddr_i - 12'h00C) << 1);
   sequence s_take;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence
   chk_ready_wait:
      assert property (s_take |=> s_answer) else $error("ready pulse");
   chk_err_unmapped:
      assert property (pready_o && paddr_i > 12'h024 |->
         pslverr_o && (pwrite_i || prdata_o == 32'h0))
         else $error("unmapped");
   chk_no_err:
      assert property (pready_o && paddr_i < 12'h028 &&
         paddr_i[1:0] == 2'b00 |-> !pslverr_o)
         else $error("mapped refused");
   chk_oe_readback:
      assert property (rd_ok && paddr_i == 12'h008 |->
         sclk_oe_o == !(prdata_o[15] || prdata_o[14]) &&
         prdata_o[31:16] == 16'h0) else $error("pin direction");
   chk_reset_oe:
      assert property (disable iff (1'b0) rst_i ##1 !rst_i |=> sclk_oe_o)
         else $error("pin not output after reset");
   chk_reset_empty:
      assert property (disable iff (1'b0) rst_i ##1 !rst_i |=> tx_irq_o)
         else $error("empty not set by reset");
   chk_tx_clear:
      assert property (s_take and pwrite_i && paddr_i >= 12'h018 &&
         paddr_i <= 12'h024 |-> ##[2:5] !tx_irq_o) else $error("empty");
   chk_rx_lanes:
      assert property (rd_ok && paddr_i >= 12'h00C && paddr_i <= 12'h014
         |-> (prdata_o & ~lane) == 32'h0) else $error("rx lane");
endmodule // scp_asserts
`default_nettype wire

/* File: testbench/scp_partner.sv */
`default_nettype none
// ****
// far-side serial device
// ****
module scp_partner (
   input  wire logic txd_i,
   output var  logic rxd_o,
   output var  logic xclk_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic xclk_en = 1'b0;
   initial rxd_o = 1'b1;
   // 16x clock, held low while xclk_en is clear
   always begin
      xclk_o = xclk_en ? ~xclk_o : 1'b0;
      #100;
   end
   task automatic send(input logic [8:0] d, input int n, input int t);
      rxd_o = 1'b0;
      #t;
      for (int i = 0; i < n; i++) begin
         rxd_o = d[i];
         #t;
      end
      rxd_o = 1'b1;
      #t;
   endtask
   // bit n of d holds the stop bit
   task automatic recv(input int n, input int t, output logic [9:0] d);
      d = 10'h000;
      @(negedge txd_i);
      #(t / 2);
      for (int i = 0; i <= n; i++) begin
         #t;
         d[i] = txd_i;
      end
   endtask
endmodule // scp_partner
`default_nettype wire

/* File: testbench/serial_port_clock_and_data_path_tb_top.sv */
`default_nettype none
`include "scp_regs.vh"
module serial_port_clock_and_data_path_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] q;
   logic [9:0]  got;
   logic        last_err;
   wire  [31:0] prdata_o;
   wire         pready_o, pslverr_o, rxd_i, txd_o, sclk_o, sclk_oe_o;
   wire         timer_irq_o, tx_irq_o, xclk;
   wire         sclk_i = sclk_oe_o ? sclk_o : xclk;
   int          err_total = 0;
   int          n_tests = 0;
   int          pin_cnt = 0;
   scp_serial_port dut_u (
      .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i, .txd_o,
      .sclk_i, .sclk_o, .sclk_oe_o, .timer_irq_o, .tx_irq_o
   );
   scp_partner p_u (.txd_i(txd_o), .rxd_o(rxd_i), .xclk_o(xclk));
   initial forever #25 clk_i = ~clk_i;
   always @(posedge sclk_i) pin_cnt++;
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      q = prdata_o;
      last_err = pslverr_o;
      chk("pready", 32'h1, {31'h0, pready_o});
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_st(input int b, input int lim);
      int i;
      i = 0;
      do begin
         apb(1'b0, `SCP_OFS_STAT, 32'h0);
         i++;
      end while (q[b] !== 1'b1 && i < lim);
      chk("status poll", 32'h1, {31'h0, q[b]});
   endtask
   function automatic logic [9:0] frame(input logic [7:0] b,
      input logic [2:0] f, input logic dir, input logic ab);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) r[i] = dir ? b[7 - i] : b[i];
      case (f)
         `SCP_FMT_A10:  return {2'b01, r};
         `SCP_FMT_EVEN: return {1'b1, ^b, r};
         `SCP_FMT_ODD:  return {1'b1, ~^b, r};
         default:       return {1'b1, ab, r};
      endcase
   endfunction
   task automatic t_reset();
      apb(1'b0, `SCP_OFS_CLKCTL, 32'h0);
      chk("clkctl", 32'h0, q);
      chk("pin out", 32'h1, {31'h0, sclk_oe_o});
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("tx empty", 32'h1, {31'h0, q[`SCP_ST_TXE]});
      apb(1'b0, 12'h028, 32'h0);
      chk("unmapped", 32'h1, {31'h0, last_err});
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `SCP_OFS_CLKCTL, {16'hFFFF, k[1:0], 14'h3FFF});
         apb(1'b0, `SCP_OFS_CLKCTL, 32'h0);
         chk("clkctl", {16'h0, k[1:0], 14'h3FFF}, q);
         chk("pin dir", {31'h0, k == 0}, {31'h0, sclk_oe_o});
      end
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_frames();
      logic [11:0] ta [7] = '{12'h018, 12'h01C, 12'h020, 12'h018,
                             12'h018, 12'h024, 12'h018};
      logic [2:0]  tf [7] = '{3'h2, 3'h2, 3'h2, 3'h4, 3'h5, 3'h6, 3'h6};
      logic [7:0]  tb [7] = '{8'hA7, 8'hB5, 8'hC3, 8'hA7, 8'hA7, 8'hA7,
                             8'hA7};
      for (int k = 0; k < 7; k++) begin
         wait_st(`SCP_ST_IDLE_TX, 50);
         apb(1'b1, `SCP_OFS_CTRL, {28'h0, k == 2, tf[k]});
         apb(1'b1, ta[k], 32'h00C3B5A7);
         apb(1'b0, `SCP_OFS_STAT, 32'h0);
         chk("tx empty", 32'h0, {31'h0, q[`SCP_ST_TXE]});
         chk("tx irq", 32'h0, {31'h0, tx_irq_o});
         p_u.recv(tf[k] == 3'h2 ? 8 : 9, 1600, got);
         chk("frame", {22'h0, frame(tb[k], tf[k], k == 2, k == 5)},
             {22'h0, got});
      end
      $display("frame test done");
   endtask
   task automatic t_rx();
      apb(1'b1, `SCP_OFS_CTRL, 32'h00000002);
      // drain what the free-running synchronous receiver left behind
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      apb(1'b0, `SCP_OFS_RX_LOW, 32'h0);
      p_u.send(9'h05A, 8, 1600);
      wait_st(`SCP_ST_RXF, 40);
      apb(1'b0, `SCP_OFS_RX_LOW, 32'h0);
      chk("rx low", 32'h0000005A, q);
      apb(1'b0, `SCP_OFS_RX_MID, 32'h0);
      chk("rx mid", 32'h00005A00, q);
      apb(1'b0, `SCP_OFS_RX_HIGH, 32'h0);
      chk("rx high", 32'h005A0000, q);
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("rx full", 32'h0, {31'h0, q[`SCP_ST_RXF]});
      // ninth bit low lands where the stop bit belongs
      p_u.send(9'h0C3, 9, 1600);
      wait_st(`SCP_ST_FRM, 40);
      $display("rx test done");
   endtask
   task automatic t_ext();
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h0000C000);
      p_u.xclk_en = 1'b1;
      chk("pin in", 32'h0, {31'h0, sclk_oe_o});
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      apb(1'b0, `SCP_OFS_RX_LOW, 32'h0);
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("frm clear", 32'h0, {31'h0, q[`SCP_ST_FRM]});
      p_u.send(9'h0A3, 8, 3200);
      wait_st(`SCP_ST_RXF, 40);
      apb(1'b0, `SCP_OFS_RX_LOW, 32'h0);
      chk("ext rx", 32'h000000A3, q);
      apb(1'b1, `SCP_OFS_TX_LOW, 32'h0000003C);
      p_u.recv(8, 3200, got);
      chk("ext tx", 32'h0000013C, {22'h0, got});
      p_u.xclk_en = 1'b0;
      $display("ext clock test done");
   endtask
   task automatic t_rate();
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h00002001);
      apb(1'b1, `SCP_OFS_TX_LOW, 32'h0000005C);
      p_u.recv(8, 25600, got);
      chk("slow frame", 32'h0000015C, {22'h0, got});
      wait_st(`SCP_ST_IDLE_TX, 200);
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h0);
      pin_cnt = 0;
      repeat (1024) @(posedge clk_i);
      chk("pin 1x", 32'h1, {31'h0, pin_cnt inside {[31:33]}});
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h00001000);
      pin_cnt = 0;
      repeat (64) @(posedge clk_i);
      chk("pin 16x", 32'h1, {31'h0, pin_cnt inside {[31:33]}});
      $display("rate test done");
   endtask
   task automatic t_timer();
      int i;
      apb(1'b1, `SCP_OFS_CLKCTL, 32'h000000FF);
      repeat (1500) @(posedge clk_i);
      chk("irq masked", 32'h0, {31'h0, timer_irq_o});
      apb(1'b1, `SCP_OFS_CTRL, 32'h00000022);
      i = 0;
      while (timer_irq_o !== 1'b1 && i < 20000) begin
         @(posedge clk_i);
         i++;
      end
      chk("irq raised", 32'h1, {31'h0, timer_irq_o});
      apb(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("irq pending", 32'h1, {31'h0, q[`SCP_ST_TMR]});
      repeat (3) @(posedge clk_i);
      chk("irq cleared", 32'h0, {31'h0, timer_irq_o});
      $display("timer test done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #3000000;
      err_total++;
      $display("BAD watchdog exp done got hang");
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_frames();
      t_rx();
      t_ext();
      t_rate();
      t_timer();
      give_verdict();
   end
endmodule // serial_port_clock_and_data_path_tb_top
bind scp_serial_port scp_asserts chk_u (.clk_i, .rst_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
   .sclk_oe_o, .tx_irq_o);
`default_nettype wire
